//--- common/lasc_consts.svh
`ifndef LASC_CONSTS_SVH
`define LASC_CONSTS_SVH

// Clock period in ps (200 MHz)
`define LASC_CLK_PERIOD_PS   5000
// Entry qualification interval in ns
`define LASC_QUAL_TIME_NS    1000000
`define LASC_QUAL_CYCLES     ((`LASC_QUAL_TIME_NS * 1000) / `LASC_CLK_PERIOD_PS)
// Upstream exit follow latency in ns
`define LASC_EXIT_LAT_NS     1000
`define LASC_EXIT_LAT_CYCLES ((`LASC_EXIT_LAT_NS * 1000) / `LASC_CLK_PERIOD_PS)
// Link control ASPM field encodings
`define LASC_ASPM_L1_BIT     1
// Number of downstream ports in the partition
`define LASC_NUM_DSP         4

`endif

//--- common/lasc_pkg.sv
package lasc_pkg;

  typedef enum logic [1:0] {
    LASC_LINK_L0,
    LASC_LINK_L0S,
    LASC_LINK_L1,
    LASC_LINK_OTHER
  } lasc_link_e;

  typedef enum logic [2:0] {
    LASC_ST_ACTIVE,
    LASC_ST_US_REQ,
    LASC_ST_DS_ACK,
    LASC_ST_L1,
    LASC_ST_EXIT
  } lasc_state_e;

  // Transmit and receive side activity of this port
  typedef struct packed {
    logic tlp_pending;
    logic dllp_pending;
    logic acknak_pending;
    logic replay_empty;
    logic rx_tlp_seen;
    logic rx_dllp_seen;
    logic credits_ok;
    logic tlp_sched;
  } lasc_port_act_s;

  // Status of one downstream port as seen by the upstream port
  typedef struct packed {
    logic in_l1;
    logic exit_start;
    logic low_power;
    logic link_down;
  } lasc_dsp_stat_s;

endpackage

//--- hdl/lasc_l1_ctrl.sv
`timescale 1ns/1ps
`include "lasc_consts.svh"
// Function
// - Downstream mode accepts L1 request only if enabled and no TLP/ACK/NAK pending
// - Downstream mode rejects L1 request when any acceptance condition fails
// - Upstream mode needs entry conditions held continuously for 1 ms
// - Upstream requests L1 only while link is in L0 or L0s
// - Partner ack enters L1; partner nak falls back to L0s attempt
// - Upstream needs L1 enabled and all active downstream ports in L1
// - Upstream needs no TLP, no DLLP pending and empty replay buffer
// - Upstream needs receiver idle for the whole 1 ms interval
// - Upstream needs credits for largest packet of each type
// - Upstream exits L1 on scheduled TLP or downstream port exit start
// - Upstream starts exit within 1 us of a downstream exit start
// - ASPM L1 enabled by link control register field; hardware does rest
// - Only the upstream-facing component initiates; downstream only answers
// - Accept sends Ack DLLPs until partner idles or a TLP is scheduled; reject sends a Nak every cycle the request is seen
// - Downstream exits L1 on scheduled TLP or upstream port exit start
module lasc_l1_ctrl
  import lasc_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_clk_en,
  // Mode and link control register ASPM field
  input  wire logic                     i_upstream_mode,
  input  wire logic [1:0]               i_aspm_ctl,
  input  wire lasc_link_e               i_link_state,
  // Port activity
  input  wire lasc_port_act_s           i_act,
  // Partner handshake
  input  wire logic                     i_partner_l1_req,
  input  wire logic                     i_partner_ack,
  input  wire logic                     i_partner_nak,
  input  wire logic                     i_partner_elec_idle,
  // Partition peers
  input  wire lasc_dsp_stat_s [`LASC_NUM_DSP-1:0] i_dsp_stat,
  input  wire logic                     i_usp_exit_start,
  // Link side requests
  output logic                          o_send_l1_req,
  output logic                          o_send_req_ack,
  output logic                          o_send_nak,
  output logic                          o_try_l0s,
  output logic                          o_start_exit,
  // Status to partition peers
  output logic                          o_in_l1,
  output logic                          o_exit_start
);

  localparam int QW = $clog2(`LASC_QUAL_CYCLES + 1);

  lasc_state_e      state_q, state_d;
  logic [QW-1:0]    qual_cnt_q, qual_cnt_d;
  logic             req_q, req_d, ack_q, ack_d, nak_q, nak_d;
  logic             l0s_q, l0s_d, exit_q, exit_d;
  logic             l1_en, cond_ok, qualified, dsp_l1_ok, dsp_exit;
  logic [`LASC_NUM_DSP-1:0] dsp_ok_vec, dsp_exit_vec;

  assign l1_en = i_aspm_ctl[`LASC_ASPM_L1_BIT];

  // Per downstream port: idle in L1, or excluded when low power or down
  genvar g;
  generate
    for (g = 0; g < `LASC_NUM_DSP; g++) begin : g_dsp
      assign dsp_ok_vec[g] = i_dsp_stat[g].in_l1 |
                             i_dsp_stat[g].low_power |
                             i_dsp_stat[g].link_down;
      assign dsp_exit_vec[g] = i_dsp_stat[g].exit_start;
    end
  endgenerate
  assign dsp_l1_ok = &dsp_ok_vec;
  assign dsp_exit  = |dsp_exit_vec;

  // Any received TLP or DLLP breaks idleness and restarts the interval
  assign cond_ok = l1_en & dsp_l1_ok &
                   ~i_act.tlp_pending & ~i_act.dllp_pending &
                   i_act.replay_empty &
                   ~i_act.rx_tlp_seen & ~i_act.rx_dllp_seen &
                   i_act.credits_ok;
  assign qualified = (qual_cnt_q == QW'(`LASC_QUAL_CYCLES));

  always_comb begin
    state_d    = state_q;
    qual_cnt_d = qual_cnt_q;
    req_d      = 1'b0;
    ack_d      = 1'b0;
    nak_d      = 1'b0;
    l0s_d      = 1'b0;
    exit_d     = 1'b0;
    if (!i_upstream_mode || !cond_ok) begin
      qual_cnt_d = '0;
    end else if (!qualified) begin
      qual_cnt_d = qual_cnt_q + QW'(1);
    end
    case (state_q)
      LASC_ST_ACTIVE: begin
        if (i_upstream_mode) begin
          if (qualified && cond_ok &&
              (i_link_state == LASC_LINK_L0 ||
               i_link_state == LASC_LINK_L0S)) begin
            state_d = LASC_ST_US_REQ;
            req_d   = 1'b1;
          end
        end else if (i_partner_l1_req) begin
          if (l1_en && !i_act.tlp_pending && !i_act.acknak_pending) begin
            state_d = LASC_ST_DS_ACK;
            ack_d   = 1'b1;
          end else begin
            nak_d = 1'b1;
          end
        end
      end
      LASC_ST_US_REQ: begin
        // Exit causes abort the request rather than racing the partner
        if (i_act.tlp_sched || dsp_exit || !i_upstream_mode) begin
          state_d = LASC_ST_ACTIVE;
          qual_cnt_d = '0;
        end else if (i_partner_ack) begin
          state_d = LASC_ST_L1;
        end else if (i_partner_nak) begin
          state_d    = LASC_ST_ACTIVE;
          qual_cnt_d = '0;
          l0s_d      = 1'b1;
        end else begin
          req_d = 1'b1;
        end
      end
      LASC_ST_DS_ACK: begin
        if (i_partner_elec_idle) begin
          state_d = LASC_ST_L1;
        end else if (i_act.tlp_sched) begin
          state_d = LASC_ST_ACTIVE;
        end else begin
          ack_d = 1'b1;
        end
      end
      LASC_ST_L1: begin
        if (i_upstream_mode ? (i_act.tlp_sched || dsp_exit)
                            : (i_act.tlp_sched ||
                               i_usp_exit_start)) begin
          state_d = LASC_ST_EXIT;
          exit_d  = 1'b1;
        end
      end
      LASC_ST_EXIT: begin
        state_d    = LASC_ST_ACTIVE;
        qual_cnt_d = '0;
      end
      default: begin
        state_d = LASC_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= LASC_ST_ACTIVE;
      qual_cnt_q <= '0;
      req_q      <= 1'b0;
      ack_q      <= 1'b0;
      nak_q      <= 1'b0;
      l0s_q      <= 1'b0;
      exit_q     <= 1'b0;
    end else if (i_clk_en) begin
      state_q    <= state_d;
      qual_cnt_q <= qual_cnt_d;
      req_q      <= req_d;
      ack_q      <= ack_d;
      nak_q      <= nak_d;
      l0s_q      <= l0s_d;
      exit_q     <= exit_d;
    end
  end

  // In-L1 status is a registered level; exit start a one-cycle pulse
  logic in_l1_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_l1_q <= 1'b0;
    end else if (i_clk_en) begin
      in_l1_q <= (state_d == LASC_ST_L1);
    end
  end

  assign o_send_l1_req  = req_q;
  assign o_send_req_ack = ack_q;
  assign o_send_nak     = nak_q;
  assign o_try_l0s      = l0s_q;
  assign o_start_exit   = exit_q;
  assign o_exit_start   = exit_q;
  assign o_in_l1        = in_l1_q;

  a_ds_accept: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && !i_upstream_mode && state_q == LASC_ST_ACTIVE &&
    i_partner_l1_req && l1_en && !i_act.tlp_pending &&
    !i_act.acknak_pending |=> o_send_req_ack)
    else $error("accept not sent");

  a_ds_reject: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && !i_upstream_mode && state_q == LASC_ST_ACTIVE &&
    i_partner_l1_req && (!l1_en || i_act.tlp_pending ||
    i_act.acknak_pending) |=> o_send_nak && !o_send_req_ack)
    else $error("reject not sent");

  a_us_qual_req: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    $rose(o_send_l1_req) |-> i_upstream_mode &&
    $past(qual_cnt_q) == QW'(`LASC_QUAL_CYCLES))
    else $error("request before full interval");

  a_us_link_l0: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    $rose(o_send_l1_req) |-> $past(i_link_state == LASC_LINK_L0 ||
    i_link_state == LASC_LINK_L0S))
    else $error("request outside L0/L0s");

  a_us_nak_l0s: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && state_q == LASC_ST_US_REQ && !i_act.tlp_sched &&
    !dsp_exit && i_upstream_mode && !i_partner_ack && i_partner_nak
    |=> o_try_l0s && !o_send_l1_req)
    else $error("no L0s fallback");

  a_qual_restart: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && !cond_ok |=> qual_cnt_q == '0)
    else $error("qualification not restarted");

  a_us_exit_lat: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && i_upstream_mode && state_q == LASC_ST_L1 && dsp_exit
    |=> o_start_exit)
    else $error("exit latency exceeded");

  a_ds_exit: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && !i_upstream_mode && state_q == LASC_ST_L1 &&
    (i_act.tlp_sched || i_usp_exit_start) |=> o_exit_start ##1
    !o_exit_start)
    else $error("downstream exit missing");

  // Only the downstream-facing role answers partner requests
  a_us_no_answer: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && i_upstream_mode && state_q == LASC_ST_ACTIVE
    |=> !o_send_nak && !o_send_req_ack)
    else $error("upstream answered request");

  a_ds_no_init: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && !i_upstream_mode && state_q == LASC_ST_ACTIVE
    |=> !o_send_l1_req)
    else $error("downstream initiated L1");

  // Acks must keep flowing, a gap could look like a withdrawn accept
  a_ack_until_idle: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && state_q == LASC_ST_DS_ACK && !i_partner_elec_idle &&
    !i_act.tlp_sched |=> o_send_req_ack)
    else $error("ack stream broken");

  a_ds_idle_l1: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && state_q == LASC_ST_DS_ACK && i_partner_elec_idle
    |=> o_in_l1 && !o_send_req_ack)
    else $error("no L1 after partner idle");

  a_us_ack_l1: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && state_q == LASC_ST_US_REQ && i_upstream_mode &&
    !i_act.tlp_sched && !dsp_exit && i_partner_ack
    |=> o_in_l1 && !o_send_l1_req)
    else $error("no L1 after partner ack");

  a_l0s_pulse: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && o_try_l0s |=> !o_try_l0s)
    else $error("fallback pulse too long");

  a_us_exit_sched: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && i_upstream_mode && state_q == LASC_ST_L1 &&
    i_act.tlp_sched |=> o_start_exit)
    else $error("no exit on scheduled TLP");

  a_us_need_peers: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    $rose(o_send_l1_req) |-> $past(l1_en && dsp_l1_ok))
    else $error("request with active peers");

  // Transmit, receive and credit checks all fold into cond_ok
  a_us_tx_idle: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    $rose(o_send_l1_req) |-> $past(cond_ok))
    else $error("request while port busy");

  // Peers sample the exit flag as a pulse, a level would retrigger them
  a_exit_pulse: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n)
    i_clk_en && o_exit_start |=> !o_exit_start)
    else $error("exit status too long");

endmodule // lasc_l1_ctrl

//--- dv/lasc_partner_model.sv
`timescale 1ns/1ps
module lasc_partner_model (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // Bench control
  input  wire logic i_want_l1,
  input  wire logic i_answer_ack,
  // From the port
  input  wire logic i_send_l1_req,
  input  wire logic i_send_req_ack,
  input  wire logic i_send_nak,
  // To the port
  output logic      o_l1_req,
  output logic      o_ack,
  output logic      o_nak,
  output logic      o_elec_idle
);
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_l1_req    <= 1'b0;
      o_ack       <= 1'b0;
      o_nak       <= 1'b0;
      o_elec_idle <= 1'b0;
    end else begin
      // Request repeats until answered; a nak withdraws it
      o_l1_req    <= i_want_l1 & ~i_send_nak & ~o_elec_idle;
      // Idle only once acks were seen
      o_elec_idle <= i_want_l1 & (o_elec_idle | i_send_req_ack);
      // One answer pulse per request
      o_ack       <= i_send_l1_req & i_answer_ack & ~o_ack;
      o_nak       <= i_send_l1_req & ~i_answer_ack & ~o_nak;
    end
  end
endmodule // lasc_partner_model

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "lasc_consts.svh"
module testbench;
  import lasc_pkg::*;
  logic clk = 0, rst_n = 0, up_mode = 0, want = 0, usp_ex = 0;
  logic [1:0]     aspm = 2'h2;
  lasc_link_e     link = LASC_LINK_L0;
  // Replay empty and credits ok: the clean activity word
  lasc_port_act_s act = 8'h12;
  lasc_dsp_stat_s [`LASC_NUM_DSP-1:0] dsp = '0;
  logic p_req, p_ack, p_nak, p_idle, l1_req, rq_ack, nak, l0s;
  logic st_ex, in_l1, ex_st;
  int   err_count = 0, n_checks = 0;

  always #2.5 clk = ~clk;

  lasc_l1_ctrl lasc_l1_ctrl_i (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(1'b1), .i_upstream_mode(up_mode), .i_aspm_ctl(aspm),
    .i_link_state(link), .i_act(act), .i_partner_l1_req(p_req),
    .i_partner_ack(p_ack), .i_partner_nak(p_nak),
    .i_partner_elec_idle(p_idle), .i_dsp_stat(dsp),
    .i_usp_exit_start(usp_ex), .o_send_l1_req(l1_req),
    .o_send_req_ack(rq_ack), .o_send_nak(nak), .o_try_l0s(l0s),
    .o_start_exit(st_ex), .o_in_l1(in_l1), .o_exit_start(ex_st));

  lasc_partner_model lasc_partner_model_i (.i_ref_clk(clk),
    .i_reset_n(rst_n), .i_want_l1(want), .i_answer_ack(1'b1),
    .i_send_l1_req(l1_req), .i_send_req_ack(rq_ack), .i_send_nak(nak),
    .o_l1_req(p_req), .o_ack(p_ack), .o_nak(p_nak), .o_elec_idle(p_idle));

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_ds_cycle(input int k);
    int   n;
    logic seen;
    seen = 0;
    n = 0;
    @(posedge clk); want <= 1'b1;
    while (in_l1 !== 1'b1 && n < 20) begin
      @(negedge clk); n++;
      if (rq_ack === 1'b1) seen = 1'b1;
    end
    chk(seen && nak === 1'b0, "no accept");
    chk(in_l1 === 1'b1, "no L1 after idle");
    @(posedge clk);
    if (k == 0) act <= 8'h13;
    else usp_ex <= 1'b1;
    @(posedge clk); act <= 8'h12; usp_ex <= 1'b0;
    @(negedge clk);
    chk(ex_st === 1'b1 && in_l1 === 1'b0, "no exit pulse");
    @(negedge clk);
    chk(ex_st === 1'b0, "exit pulse too long");
    @(posedge clk); want <= 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_ds_reject(input logic [1:0] a, input logic [7:0] ac);
    int   n;
    logic got;
    got = 0;
    @(posedge clk); aspm <= a; act <= ac; want <= 1'b1;
    for (n = 0; n < 10; n++) begin
      @(negedge clk);
      if (nak === 1'b1) got = 1'b1;
      chk(rq_ack === 1'b0 && in_l1 === 1'b0, "bad accept");
    end
    chk(got, "no nak");
    // Withdraw the request first so a late one cannot be accepted
    @(posedge clk); want <= 1'b0;
    repeat (4) @(posedge clk);
    aspm <= 2'h2; act <= 8'h12;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_us_refuse();
    int n;
    @(posedge clk); up_mode <= 1'b1; act <= 8'h92; want <= 1'b1;
    for (n = 0; n < 10; n++) begin
      @(negedge clk);
      chk(rq_ack === 1'b0 && nak === 1'b0, "upstream answered");
    end
    @(posedge clk); want <= 1'b0;
  endtask

  task automatic t_us_entry();
    int n;
    // Two peers in L1, one in low power, one link down
    @(posedge clk); link <= LASC_LINK_L0S; act <= 8'h12; dsp <= 16'h8128;
    repeat (50) @(negedge clk);
    @(posedge clk); act <= 8'h1A;
    @(posedge clk); act <= 8'h12;
    n = 0;
    while (l1_req !== 1'b1 && n < 200010) begin
      @(negedge clk); n++;
    end
    chk(n >= `LASC_QUAL_CYCLES && n <= `LASC_QUAL_CYCLES + 4,
        "qualification length");
    n = 0;
    while (in_l1 !== 1'b1 && n < 10) begin
      @(negedge clk); n++;
    end
    chk(in_l1 === 1'b1 && l1_req === 1'b0, "no L1 on ack");
    @(posedge clk); dsp <= 16'hC128;
    @(posedge clk); dsp <= 16'h0128;
    n = 0;
    // One microsecond is 200 cycles
    while (st_ex !== 1'b1 && n < 200) begin
      @(negedge clk); n++;
    end
    chk(st_ex === 1'b1, "upstream exit late");
  endtask

  initial begin
    #(250000 * 5);
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({l1_req, rq_ack, nak, l0s, st_ex, in_l1} === 6'h00, "reset");
    t_ds_cycle(0);
    t_ds_cycle(1);
    t_ds_reject(2'h1, 8'h12);
    t_ds_reject(2'h2, 8'h92);
    t_ds_reject(2'h2, 8'h32);
    t_us_refuse();
    t_us_entry();
    end_sim();
  end
endmodule // testbench
